// [rtl/rbt_params.svh]
`ifndef RBT_PARAMS_SVH
`define RBT_PARAMS_SVH

// Register byte addresses, low twelve bits decoded
`define RBT_ADDR_W 12
`define RBT_ADDR_CTRL 12'h000
`define RBT_ADDR_STAT 12'h004
`define RBT_ADDR_LOG 12'h008

// Control register fields
`define RBT_CTRL_AB_LO 0
`define RBT_CTRL_AB_HI 1
`define RBT_CTRL_BA_LO 2
`define RBT_CTRL_BA_HI 3
`define RBT_CTRL_LOOP 4
`define RBT_CTRL_AOE 5
`define RBT_CTRL_BEN_HI 6
`define RBT_CTRL_BEN_LO 7
`define RBT_CTRL_W 8
`define RBT_CTRL_RST 8'h80

// Status register fields
`define RBT_STAT_AB_LSB 0
`define RBT_STAT_BA_LSB 8
`define RBT_STAT_NEMPTY 16
`define RBT_STAT_OVF 17
`define RBT_STAT_LREADY 18

// Log read word: data in low byte, valid flag on top
`define RBT_LOG_VALID 31

// Pin synchroniser reset value: data low, B lines idle high, strobes low
`define RBT_PIN_W 18
`define RBT_PIN_RST 18'h0ff00

`endif

// [rtl/rbt_pkg.sv]
package rbt_pkg;

  // Logic element kind, Gray coded
  typedef enum logic [1:0] {
    RBT_BUF = 2'b00,
    RBT_FF = 2'b01,
    RBT_LATCH = 2'b11
  } rbt_mode_t;

  // Two select bits to element kind; a high upper bit always means latch
  function automatic rbt_mode_t rbt_decode(input logic hi, input logic lo);
    rbt_mode_t m;
    m = RBT_BUF;
    if (hi) begin
      m = RBT_LATCH;
    end else if (lo) begin
      m = RBT_FF;
    end
    return m;
  endfunction

endpackage

// [rtl/rbt_element.sv]
`timescale 1ns/100ps
module rbt_element
  import rbt_pkg::*;
#(
  parameter int WIDTH = 8
) (
  input wire logic clk,
  input wire logic rstn,
  input wire logic ce,
  input wire rbt_mode_t mode,
  input wire logic strobe,
  input wire logic [WIDTH-1:0] d,
  output logic [WIDTH-1:0] p,
  output logic [WIDTH-1:0] q,
  output logic cap
);

  logic strobe_q;
  logic [WIDTH-1:0] store_q;
  logic rise;
  logic store_en;

  assign rise = strobe & ~strobe_q;
  // Storage follows the mode even while outputs are off
  assign store_en = ((mode == RBT_FF) && rise) || ((mode == RBT_LATCH) && strobe);

  // Strobe history for edge detect
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      strobe_q <= 1'b0;
    end else if (ce) begin
      strobe_q <= strobe;
    end
  end

  // Stored word, taken on rising strobe or while latch is open
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      store_q <= '0;
    end else if (ce && store_en) begin
      store_q <= d;
    end
  end

  // Point before inversion
  always_comb begin
    case (mode)
      RBT_BUF: p = d;
      RBT_FF: p = store_q;
      RBT_LATCH: p = strobe ? d : store_q;
      default: p = store_q;
    endcase
  end

  assign q = ~p;
  assign cap = ce && (mode == RBT_FF) && rise;

endmodule // rbt_element

// [rtl/rbt_fifo.sv]
`timescale 1ns/100ps
module rbt_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 8
) (
  input wire logic clk,
  input wire logic rstn,
  input wire logic ce,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);

  localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

  logic [WIDTH-1:0] mem_q [DEPTH];
  logic [AW-1:0] wr_q;
  logic [AW-1:0] rd_q;
  logic [AW:0] cnt_q;
  logic push;
  logic pop;

  assign in_ready = (cnt_q != (AW+1)'(DEPTH));
  assign out_valid = (cnt_q != '0);
  assign push = ce && in_valid && in_ready;
  assign pop = ce && out_valid && out_ready;
  assign out_data = mem_q[rd_q];

  // Storage write
  always_ff @(posedge clk) begin
    if (push) begin
      mem_q[wr_q] <= in_data;
    end
  end

  // Pointers wrap at DEPTH, which need not be a power of two
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      wr_q <= '0;
      rd_q <= '0;
      cnt_q <= '0;
    end else begin
      if (push) begin
        wr_q <= (wr_q == AW'(DEPTH - 1)) ? '0 : wr_q + 1'b1;
      end
      if (pop) begin
        rd_q <= (rd_q == AW'(DEPTH - 1)) ? '0 : rd_q + 1'b1;
      end
      if (push && !pop) begin
        cnt_q <= cnt_q + 1'b1;
      end else if (pop && !push) begin
        cnt_q <= cnt_q - 1'b1;
      end
    end
  end

endmodule // rbt_fifo

// [rtl/rbt_transceiver.sv]
`timescale 1ns/100ps
`include "rbt_params.svh"
module rbt_transceiver
  import rbt_pkg::*;
#(
  parameter int WIDTH = 8,
  parameter int LOG_DEPTH = 8
) (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hclk_en,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  input wire logic [WIDTH-1:0] a_side_input_bus,
  output logic [WIDTH-1:0] a_side_output_bus,
  output logic a_side_output_oe,
  input wire logic [WIDTH-1:0] b_line_in,
  output logic [WIDTH-1:0] b_line_out,
  output logic [WIDTH-1:0] b_line_oe,
  input wire logic a_to_b_capture_strobe,
  input wire logic b_to_a_capture_strobe,
  output logic b_to_a_log_ready
);

  // ***************************************************************
  // Declarations
  // ***************************************************************

  localparam int PW = 2 * WIDTH + 2;

  logic [PW-1:0] pin_raw;
  logic [PW-1:0] pin_s1_q;
  logic [PW-1:0] pin_s2_q;
  logic [PW-1:0] pin_s3_q;
  logic [PW-1:0] pin_q;
  logic [WIDTH-1:0] a_in;
  logic [WIDTH-1:0] b_in;
  logic ab_strobe;
  logic ba_strobe;

  logic [`RBT_CTRL_W-1:0] ctrl_q;
  logic [`RBT_CTRL_W-1:0] ctrl_d;
  rbt_mode_t ab_mode;
  rbt_mode_t ba_mode;
  logic loop_sel;
  logic b_enable;

  logic [WIDTH-1:0] ab_p;
  logic [WIDTH-1:0] ab_q;
  logic [WIDTH-1:0] ba_d;
  logic [WIDTH-1:0] ba_p;
  logic [WIDTH-1:0] ba_q;
  logic ab_cap;
  logic ba_cap;

  logic [WIDTH-1:0] a_out_q;
  logic a_oe_q;
  logic [WIDTH-1:0] b_oe_q;

  logic log_in_ready;
  logic log_out_valid;
  logic log_pop;
  logic [WIDTH-1:0] log_data;
  logic ovf_q;
  logic ovf_clr;

  logic acc;
  logic dph_wr_q;
  logic [`RBT_ADDR_W-1:0] dph_addr_q;
  logic wr_now;
  logic ctrl_wr;
  logic [31:0] hrdata_q;
  logic [`RBT_ADDR_W-1:0] a_addr;
  logic [`RBT_CTRL_W-1:0] ctrl_rd;
  logic [31:0] stat_word;
  logic [31:0] log_word;
  logic [WIDTH-1:0] b_pull_d;

  // ***************************************************************
  // Pin synchronisers
  // ***************************************************************

  assign pin_raw = {b_to_a_capture_strobe, a_to_b_capture_strobe, b_line_in, a_side_input_bus};

  // Three stages; the first stage only feeds the second
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      pin_s1_q <= PW'(`RBT_PIN_RST);
      pin_s2_q <= PW'(`RBT_PIN_RST);
      pin_s3_q <= PW'(`RBT_PIN_RST);
    end else if (hclk_en) begin
      pin_s1_q <= pin_raw;
      pin_s2_q <= pin_s1_q;
      pin_s3_q <= pin_s2_q;
    end
  end

  // A bit moves only once the last two stages agree, filtering one-cycle glitches
  genvar gi;
  generate
    for (gi = 0; gi < PW; gi++) begin : g_pin
      always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
          pin_q[gi] <= 1'(`RBT_PIN_RST >> gi);
        end else if (hclk_en && (pin_s2_q[gi] == pin_s3_q[gi])) begin
          pin_q[gi] <= pin_s3_q[gi];
        end
      end
    end
  endgenerate

  // Eight bits in each direction
  assign a_in = pin_q[WIDTH-1:0];
  assign b_in = pin_q[2*WIDTH-1:WIDTH];
  assign ab_strobe = pin_q[2*WIDTH];
  assign ba_strobe = pin_q[2*WIDTH+1];

  // ***************************************************************
  // Mode and enable decode
  // ***************************************************************

  // Shared decoder keeps both directions identical
  assign ab_mode = rbt_decode(ctrl_q[`RBT_CTRL_AB_HI], ctrl_q[`RBT_CTRL_AB_LO]);
  assign ba_mode = rbt_decode(ctrl_q[`RBT_CTRL_BA_HI], ctrl_q[`RBT_CTRL_BA_LO]);
  assign loop_sel = ctrl_q[`RBT_CTRL_LOOP];
  // The B port may pull only with the high enable set and the low enable clear
  assign b_enable = ctrl_q[`RBT_CTRL_BEN_HI] & ~ctrl_q[`RBT_CTRL_BEN_LO];

  // ***************************************************************
  // Logic elements
  // ***************************************************************

  // A to B element, fed from the A input bus
  rbt_element #(
    .WIDTH(WIDTH)
  ) u_ab (
    .clk(hclk),
    .rstn(hresetn),
    .ce(hclk_en),
    .mode(ab_mode),
    .strobe(ab_strobe),
    .d(a_in),
    .p(ab_p),
    .q(ab_q),
    .cap(ab_cap)
  );

  // Return path taps the A-to-B point ahead of its inverter, any mode
  assign ba_d = loop_sel ? ab_p : b_in;

  // B to A element; runs regardless of the A output enable
  rbt_element #(
    .WIDTH(WIDTH)
  ) u_ba (
    .clk(hclk),
    .rstn(hresetn),
    .ce(hclk_en),
    .mode(ba_mode),
    .strobe(ba_strobe),
    .d(ba_d),
    .p(ba_p),
    .q(ba_q),
    .cap(ba_cap)
  );

  // ***************************************************************
  // Output pins
  // ***************************************************************

  // Registered A output and its enable; data keeps tracking while off
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      a_out_q <= '0;
      a_oe_q <= 1'b0;
    end else if (hclk_en) begin
      a_out_q <= ba_q;
      a_oe_q <= ctrl_q[`RBT_CTRL_AOE];
    end
  end

  // Each B line pulls on its own; a released line is left to the far pull-up
  genvar gb;
  generate
    for (gb = 0; gb < WIDTH; gb++) begin : g_bline
      assign b_pull_d[gb] = b_enable & ~ab_q[gb];
    end
  endgenerate

  // Open-collector B, registered so the pins never see a decode glitch
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      b_oe_q <= '0;
    end else if (hclk_en) begin
      b_oe_q <= b_pull_d;
    end
  end

  assign a_side_output_bus = a_out_q;
  assign a_side_output_oe = a_oe_q;
  assign b_line_out = '0;
  assign b_line_oe = b_oe_q;

  // ***************************************************************
  // Capture log
  // ***************************************************************

  // Flip-flop captures on the B-to-A side are queued for software
  rbt_fifo #(
    .WIDTH(WIDTH),
    .DEPTH(LOG_DEPTH)
  ) u_log (
    .clk(hclk),
    .rstn(hresetn),
    .ce(hclk_en),
    .in_valid(ba_cap),
    .in_ready(log_in_ready),
    .in_data(ba_d), // Word being stored now; the point still shows the old one
    .out_valid(log_out_valid),
    .out_ready(log_pop),
    .out_data(log_data)
  );

  assign b_to_a_log_ready = log_in_ready;

  // Lost capture is sticky; a new loss beats a clear in the same cycle
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ovf_q <= 1'b0;
    end else if (hclk_en) begin
      if (ba_cap && !log_in_ready) begin
        ovf_q <= 1'b1;
      end else if (ovf_clr) begin
        ovf_q <= 1'b0;
      end
    end
  end

  // ***************************************************************
  // Read words
  // ***************************************************************

  // A control write in flight is forwarded so a read right behind it is fresh
  assign ctrl_rd = ctrl_wr ? ctrl_d : ctrl_q;

  // Status assembled apart from the bus; element outputs are live, not sampled
  always_comb begin
    stat_word = '0;
    stat_word[`RBT_STAT_AB_LSB +: WIDTH] = ab_q;
    stat_word[`RBT_STAT_BA_LSB +: WIDTH] = ba_q;
    stat_word[`RBT_STAT_NEMPTY] = log_out_valid;
    stat_word[`RBT_STAT_OVF] = ovf_q;
    stat_word[`RBT_STAT_LREADY] = log_in_ready;
  end

  // Empty log reads zero, so stale storage never leaks out
  always_comb begin
    log_word = '0;
    if (log_out_valid) begin
      log_word[WIDTH-1:0] = log_data;
      log_word[`RBT_LOG_VALID] = 1'b1;
    end
  end

  // ***************************************************************
  // AHB-Lite slave
  // ***************************************************************

  // Zero wait states; the clock enable stalls the bus so no transfer is lost
  assign hreadyout = hclk_en;
  assign hresp = 1'b0;
  assign hrdata = hrdata_q;
  assign acc = hsel && hready && htrans[1] && hclk_en;
  assign a_addr = haddr[`RBT_ADDR_W-1:0];
  assign wr_now = dph_wr_q && hready && hclk_en;
  assign ctrl_wr = wr_now && (dph_addr_q == `RBT_ADDR_CTRL);
  assign ovf_clr = wr_now && (dph_addr_q == `RBT_ADDR_STAT) && hwdata[`RBT_STAT_OVF];
  assign log_pop = acc && !hwrite && (a_addr == `RBT_ADDR_LOG);
  assign ctrl_d = hwdata[`RBT_CTRL_W-1:0];

  // Address phase registers
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      dph_wr_q <= 1'b0;
      dph_addr_q <= '0;
    end else if (hclk_en && hready) begin
      dph_wr_q <= acc && hwrite;
      dph_addr_q <= a_addr;
    end
  end

  // Control register; writes land in the data phase
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ctrl_q <= `RBT_CTRL_RST;
    end else if (ctrl_wr) begin
      ctrl_q <= ctrl_d;
    end
  end

  // Read data is fetched in the address phase so it comes from a flop;
  // a control write in flight is forwarded to avoid a stale read
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata_q <= '0;
    end else if (acc && !hwrite) begin
      hrdata_q <= '0;
      if (a_addr == `RBT_ADDR_CTRL) begin
        hrdata_q[`RBT_CTRL_W-1:0] <= ctrl_rd;
      end else if (a_addr == `RBT_ADDR_STAT) begin
        hrdata_q <= stat_word;
      end else if (a_addr == `RBT_ADDR_LOG) begin
        hrdata_q <= log_word;
      end
    end
  end

endmodule // rbt_transceiver

// [bench/rbt_backplane_model.sv]
`timescale 1ns/100ps
// ****
// Backplane far side
// ****
module rbt_backplane_model (
  input wire logic [7:0] b_line_oe,
  input wire logic [7:0] b_line_out,
  input wire logic [7:0] far_pull,
  output logic [7:0] b_wire
);
  // Open collector: any puller wins, else the pull-up reads high
  assign b_wire = ~((b_line_oe & ~b_line_out) | far_pull);
endmodule // rbt_backplane_model

// [bench/rbt_transceiver_asserts.sv]
`timescale 1ns/100ps
`include "rbt_params.svh"
// ****
// Port checks
// ****
module rbt_transceiver_asserts #(
  parameter int WIDTH = 8
) (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hclk_en,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  input wire logic [31:0] hrdata,
  input wire logic hreadyout,
  input wire logic hresp,
  input wire logic [WIDTH-1:0] a_side_input_bus,
  input wire logic [WIDTH-1:0] a_side_output_bus,
  input wire logic a_side_output_oe,
  input wire logic [WIDTH-1:0] b_line_in,
  input wire logic [WIDTH-1:0] b_line_out,
  input wire logic [WIDTH-1:0] b_line_oe,
  input wire logic a_to_b_capture_strobe,
  input wire logic b_to_a_capture_strobe,
  input wire logic b_to_a_log_ready
);
  logic take;
  logic pend_q;
  logic [11:0] wa_q;
  logic [7:0] ctrl_q;
  // Control shadow rebuilt from writes seen on the bus
  assign take = hsel && hready && htrans[1] && hclk_en;
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      pend_q <= 1'b0;
      wa_q <= 12'h000;
    end else if (hready) begin
      pend_q <= take && hwrite;
      wa_q <= haddr[11:0];
    end
  end
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ctrl_q <= `RBT_CTRL_RST;
    end else if (pend_q && hready && wa_q == `RBT_ADDR_CTRL) begin
      ctrl_q <= hwdata[7:0];
    end
  end
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);
  property p_resp_okay;
    !hresp;
  endproperty
  a_resp_okay: assert property (p_resp_okay) else $error("bus response not okay");
  property p_ready_en;
    hreadyout == hclk_en;
  endproperty
  a_ready_en: assert property (p_ready_en) else $error("ready does not follow enable");
  property p_bdata_low;
    b_line_out == '0;
  endproperty
  a_bdata_low: assert property (p_bdata_low) else $error("B data not pull-down");
  property p_aout_en;
    $stable(ctrl_q)[*3] |-> a_side_output_oe == ctrl_q[5];
  endproperty
  a_aout_en: assert property (p_aout_en) else $error("A enable wrong");
  property p_bport_gate;
    (!ctrl_q[6] || ctrl_q[7])[*3] |-> b_line_oe == '0;
  endproperty
  a_bport_gate: assert property (p_bport_gate) else $error("B drives while off");
  // Settled buffer paths; a frozen clock enable would stretch the latency
  property p_buf_ab;
    (hclk_en && ctrl_q[1:0] == 2'b00 && ctrl_q[7:6] == 2'b01
      && $stable(a_side_input_bus))[*6] |-> b_line_oe == a_side_input_bus;
  endproperty
  a_buf_ab: assert property (p_buf_ab) else $error("A to B buffer wrong");
  property p_buf_ba;
    (hclk_en && ctrl_q[4:2] == 3'b000 && $stable(b_line_in))[*6]
      |-> a_side_output_bus == ~b_line_in;
  endproperty
  a_buf_ba: assert property (p_buf_ba) else $error("B to A buffer wrong");
  property p_unmapped;
    take && !hwrite && haddr[11:0] > `RBT_ADDR_LOG |=> hrdata == 32'h0;
  endproperty
  a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
  property p_ctrl_read;
    take && !hwrite && haddr[11:0] == `RBT_ADDR_CTRL |=> hrdata[7:0] == ctrl_q;
  endproperty
  a_ctrl_read: assert property (p_ctrl_read) else $error("control readback wrong");
endmodule // rbt_transceiver_asserts

bind rbt_transceiver rbt_transceiver_asserts #(.WIDTH(WIDTH)) i_rbt_transceiver_asserts (
  .hclk(hclk), .hresetn(hresetn), .hclk_en(hclk_en), .hsel(hsel), .haddr(haddr),
  .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready),
  .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
  .a_side_input_bus(a_side_input_bus), .a_side_output_bus(a_side_output_bus),
  .a_side_output_oe(a_side_output_oe), .b_line_in(b_line_in), .b_line_out(b_line_out),
  .b_line_oe(b_line_oe), .a_to_b_capture_strobe(a_to_b_capture_strobe),
  .b_to_a_capture_strobe(b_to_a_capture_strobe), .b_to_a_log_ready(b_to_a_log_ready));

// [bench/test_registered_bus_transceiver_8bit.sv]
`timescale 1ns/100ps
// ****
// Bench top
// ****
module test_registered_bus_transceiver_8bit;
  logic hclk, hresetn, hclk_en, hsel, hwrite, hreadyout, hresp, a_side_output_oe;
  logic a_to_b_capture_strobe, b_to_a_capture_strobe, b_to_a_log_ready;
  logic [31:0] haddr, hwdata, hrdata, rd;
  logic [1:0] htrans;
  logic [2:0] hsize;
  logic [7:0] a_side_input_bus, a_side_output_bus, b_line_in, b_line_out, b_line_oe, far_pull;
  wire logic hready;
  int num_errors = 0;
  int cmp_count = 0;
  int cycles = 0;
  assign hready = hreadyout;
  rbt_transceiver i_rbt_transceiver (.hclk(hclk), .hresetn(hresetn), .hclk_en(hclk_en),
    .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
    .hwdata(hwdata), .hready(hready), .hrdata(hrdata), .hreadyout(hreadyout),
    .hresp(hresp), .a_side_input_bus(a_side_input_bus),
    .a_side_output_bus(a_side_output_bus), .a_side_output_oe(a_side_output_oe),
    .b_line_in(b_line_in), .b_line_out(b_line_out), .b_line_oe(b_line_oe),
    .a_to_b_capture_strobe(a_to_b_capture_strobe),
    .b_to_a_capture_strobe(b_to_a_capture_strobe), .b_to_a_log_ready(b_to_a_log_ready));
  rbt_backplane_model i_rbt_backplane_model (.b_line_oe(b_line_oe), .b_line_out(b_line_out),
    .far_pull(far_pull), .b_wire(b_line_in));
  initial begin
    hclk = 1'b0;
    forever #2 hclk = ~hclk;
  end
  task results;
    $display("Comparisons %0d, mismatches %0d", cmp_count, num_errors);
    if (num_errors == 0 && cmp_count > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  // Hang guard, far above the few hundred cycles the tests need
  always @(posedge hclk) begin
    cycles++;
    if (cycles == 20000) begin
      num_errors++;
      results;
    end
  end
  task chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      num_errors++;
      $display("ERROR t=%0t got %h exp %h", $time, got, exp);
    end
  endtask
  // One single word transfer; waits on hready, never on a cycle count
  task xfer(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge hclk);
    hsel <= 1'b1;
    htrans <= 2'b10;
    haddr <= {20'h00000, a};
    hwrite <= w;
    @(posedge hclk);
    while (hready !== 1'b1) @(posedge hclk);
    hsel <= 1'b0;
    htrans <= 2'b00;
    hwdata <= d;
    @(posedge hclk);
    while (hready !== 1'b1) @(posedge hclk);
    rd = hrdata;
  endtask
  // Flip-flop path needs six edges from pin to B output; two spare
  task settle;
    repeat (8) @(posedge hclk);
  endtask
  initial begin
    {hclk_en, hsel, hwrite, htrans, haddr, hwdata} = '0;
    {a_to_b_capture_strobe, b_to_a_capture_strobe, a_side_input_bus, far_pull} = '0;
    hclk_en = 1'b1;
    hsize = 3'b010;
    hresetn = 1'b0;
    repeat (16) @(posedge hclk);
    hresetn <= 1'b1;
    // Reset state, control readback, hole in the map, stall
    chk({a_side_output_oe, b_line_oe, b_to_a_log_ready}, 32'h1);
    xfer(1'b0, 12'h000, 32'h0);
    chk(rd, 32'h80);
    xfer(1'b0, 12'h00c, 32'h0);
    chk(rd, 32'h0);
    hclk_en <= 1'b0;
    @(posedge hclk);
    #1 chk(hreadyout, 32'h0);
    @(posedge hclk);
    hclk_en <= 1'b1;
    // Buffer A to B under all four B enable pairs
    a_side_input_bus <= 8'h5a;
    for (int i = 0; i < 4; i++) begin
      xfer(1'b1, 12'h000, i << 6);
      settle;
      chk(b_line_in, (i == 1) ? 8'ha5 : 8'hff);
    end
    // Flip-flop: capture on the rise, then hold with strobe high
    xfer(1'b1, 12'h000, 32'h41);
    a_side_input_bus <= 8'h3c;
    settle;
    a_to_b_capture_strobe <= 1'b1;
    settle;
    chk(b_line_in, 8'hc3);
    a_side_input_bus <= 8'hff;
    settle;
    chk(b_line_in, 8'hc3);
    a_to_b_capture_strobe <= 1'b0;
    settle;
    // Latch: follow while open, hold when closed
    xfer(1'b1, 12'h000, 32'h43);
    a_to_b_capture_strobe <= 1'b1;
    a_side_input_bus <= 8'h0f;
    settle;
    chk(b_line_in, 8'hf0);
    a_to_b_capture_strobe <= 1'b0;
    settle;
    a_side_input_bus <= 8'hf0;
    settle;
    chk(b_line_in, 8'hf0);
    // B to A buffer, A enabled then floated while data still tracks
    xfer(1'b1, 12'h000, 32'h20);
    far_pull <= 8'h81;
    settle;
    chk({a_side_output_oe, a_side_output_bus}, 32'h181);
    xfer(1'b1, 12'h000, 32'h0);
    far_pull <= 8'h18;
    settle;
    chk({a_side_output_oe, a_side_output_bus}, 32'h018);
    // Return path takes the A-to-B point instead of the B lines
    xfer(1'b1, 12'h000, 32'h30);
    a_side_input_bus <= 8'h66;
    settle;
    chk(a_side_output_bus, 8'h99);
    // Log: nine captures into eight places, then drain to empty
    xfer(1'b1, 12'h000, 32'h04);
    for (int i = 0; i < 9; i++) begin
      far_pull <= 8'(i);
      settle;
      b_to_a_capture_strobe <= 1'b1;
      settle;
      b_to_a_capture_strobe <= 1'b0;
      settle;
    end
    chk(b_to_a_log_ready, 32'h0);
    xfer(1'b0, 12'h004, 32'h0);
    chk(rd[18:16], 3'b011);
    for (int i = 0; i < 8; i++) begin
      xfer(1'b0, 12'h008, 32'h0);
      chk(rd, {1'b1, 23'h0, ~8'(i)});
    end
    xfer(1'b0, 12'h008, 32'h0);
    chk(rd, 32'h0);
    xfer(1'b1, 12'h004, 32'h20000);
    xfer(1'b0, 12'h004, 32'h0);
    chk(rd[18:16], 3'b100);
    results;
  end
endmodule // test_registered_bus_transceiver_8bit
